// ### core/lpt_map.vh
// Purpose: constants for the low-power timer/pulse counter
// Assumes: plain Verilog-2005 includes
// Notes: selector codes and widths
`ifndef LPT_MAP_VH
`define LPT_MAP_VH

`define LPT_CNT_W 16
`define LPT_SEL_W 2
`define LPT_PSC_W 4
`define LPT_FLT_MAX 4'hf
`define LPT_SETTLE_CYC 3'h4
`define LPT_SRC_CMP 2'h0
`define LPT_SRC_PIN1 2'h1
`define LPT_SRC_PIN2 2'h2
`define LPT_SRC_PIN3 2'h3
`define LPT_CLK_IRC 2'h0
`define LPT_CLK_LPO 2'h1
`define LPT_CLK_32K 2'h2
`define LPT_CLK_EXT 2'h3
`define LPT_MODE_TIME 1'b0
`define LPT_MODE_PULSE 1'b1

`endif

// ### core/lpt_tick_gen.v
// Purpose: pick a counting clock source and derive its rising-edge ticks
// Assumes: source clocks are slow versus mclk and asynchronous to it
// Notes: each source passes a two-stage synchroniser first
`include "lpt_map.vh"
`default_nettype none

module lpt_tick_gen (
    input wire mclk,
    input wire reset_n,
    input wire [`LPT_SEL_W-1:0] clkSel,
    input wire [3:0] srcClk,
    output reg srcTick_ff
);

// ************************************************************
// synchronise all sources
// ************************************************************
reg [3:0] syncA_ff;
reg [3:0] syncB_ff;
reg selPrev_ff;

genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
        always @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                syncA_ff[gi] <= 1'b0;
                syncB_ff[gi] <= 1'b0;
            end else begin
                syncA_ff[gi] <= srcClk[gi];
                syncB_ff[gi] <= syncA_ff[gi];
            end
        end
    end
endgenerate

// ************************************************************
// edge detect on selected source
// ************************************************************
wire selLvl = syncB_ff[clkSel];

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        selPrev_ff <= 1'b0;
        srcTick_ff <= 1'b0;
    end else begin
        selPrev_ff <= selLvl;
        srcTick_ff <= selLvl & ~selPrev_ff;
    end
end

endmodule
`default_nettype wire

// ### core/lpt_timer_core.v
// Purpose: 16-bit low-power time counter or pulse counter with compare
// Assumes: config inputs are stable while disabled; mclk always runs
// Notes: reset_n is the domain reset only; system resets stay outside
//
// Notes on behaviour
// - two modes, prescaled time counting or filtered pulse counting
// - 16-bit counter and compare; equality signals compare event
// - selected clock feeds prescaler in time mode, glitch filter in pulse
// - on match either reset to zero or keep running to overflow
// - compare interrupt usable as wakeup, plus a hardware trigger
// - input select 00 comparator, 01-11 alternate pins one to three
// - clock select 00 internal, 01 1 kHz, 10 32 kHz, 11 external
// - pulse input may change any time, asynchronously, still counted
// - debug halts time counting, pulse counting continues
// - keeps running in wait, stop, low-leakage; can request wake
// - count and configuration survive ordinary system resets
// - flag sets on enabled match-and-increment; clears on disable or write
// - free-running bit 0 resets on flag, 1 only on overflow
// - interrupt asserted while enable and flag both set
`include "lpt_map.vh"
`default_nettype none

module lpt_timer_core (
    input wire mclk,
    input wire reset_n,
    input wire timerEnable,
    input wire counterMode,
    input wire [`LPT_SEL_W-1:0] pulse_input_select,
    input wire pulse_input_polarity,
    input wire [`LPT_SEL_W-1:0] prescaler_clock_select,
    input wire [`LPT_PSC_W-1:0] prescaleValue,
    input wire prescaleBypass,
    input wire free_running_select,
    input wire compare_interrupt_enable,
    input wire [`LPT_CNT_W-1:0] compare_value,
    input wire compareFlagClear,
    input wire debugHalt,
    input wire comparator_output,
    input wire [3:1] pulse_input_pin_n,
    input wire internal_reference_clock,
    input wire low_power_oscillator_1khz,
    input wire slow_external_clock_32k,
    input wire external_reference_clock,
    output reg [`LPT_CNT_W-1:0] counter_value,
    output reg compare_flag,
    output reg timerIrq,
    output reg hwTrigger
);

// ************************************************************
// clock source ticks
// ************************************************************
wire srcTick;

lpt_tick_gen uTick (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkSel(prescaler_clock_select),
    .srcClk({external_reference_clock, slow_external_clock_32k,
             low_power_oscillator_1khz, internal_reference_clock}),
    .srcTick_ff(srcTick)
);

// ************************************************************
// pulse input select and synchronise
// ************************************************************
reg pinSyncA_ff;
reg pinSyncB_ff;
reg pinPrev_ff;
reg pinRaw;

always @* begin
    case (pulse_input_select)
        `LPT_SRC_CMP: pinRaw = comparator_output;
        `LPT_SRC_PIN1: pinRaw = pulse_input_pin_n[1];
        `LPT_SRC_PIN2: pinRaw = pulse_input_pin_n[2];
        default: pinRaw = pulse_input_pin_n[3];
    endcase
end

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        pinSyncA_ff <= 1'b0;
        pinSyncB_ff <= 1'b0;
    end else begin
        pinSyncA_ff <= pinRaw;
        pinSyncB_ff <= pinSyncA_ff;
    end
end

wire pinLvl = pinSyncB_ff ^ pulse_input_polarity;

// ************************************************************
// settle window after reset
// ************************************************************
// synchronisers start at 0 whatever the pins show, so the first
// edges after reset could fake a pulse or tick; hold off counting
reg [2:0] settle_ff;
wire settled = (settle_ff == `LPT_SETTLE_CYC);

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        settle_ff <= 3'h0;
    end else if (!settled) begin
        settle_ff <= settle_ff + 3'h1;
    end
end

// ************************************************************
// glitch filter and prescaler
// ************************************************************
// filter: level must hold for 2^value source ticks before it is taken;
// a short glitch restarts the count and never reaches the counter
reg [`LPT_CNT_W-1:0] divCnt_ff;
reg [`LPT_CNT_W-1:0] nxt_divCnt;
reg filtLvl_ff;
reg nxt_filtLvl;
reg incr;

// shift amount widened so the largest prescale does not wrap to zero
wire [`LPT_CNT_W-1:0] divTop =
    (`LPT_CNT_W'h1 << ({1'b0, prescaleValue} + 5'h1)) - `LPT_CNT_W'h1;
wire [`LPT_CNT_W-1:0] fltTop =
    (`LPT_CNT_W'h1 << prescaleValue) - `LPT_CNT_W'h1;

always @* begin
    nxt_divCnt = divCnt_ff;
    nxt_filtLvl = filtLvl_ff;
    incr = 1'b0;
    if (!timerEnable || !settled) begin
        nxt_divCnt = `LPT_CNT_W'h0;
        nxt_filtLvl = pinLvl;
    end else if (counterMode == `LPT_MODE_TIME) begin
        if (srcTick && !debugHalt) begin
            if (prescaleBypass || divCnt_ff == divTop) begin
                nxt_divCnt = `LPT_CNT_W'h0;
                incr = 1'b1;
            end else begin
                nxt_divCnt = divCnt_ff + `LPT_CNT_W'h1;
            end
        end
    end else begin
        if (pinLvl == filtLvl_ff) begin
            nxt_divCnt = `LPT_CNT_W'h0;
        end else if (prescaleBypass) begin
            nxt_filtLvl = pinLvl;
            incr = pinLvl;
        end else if (srcTick) begin
            if (divCnt_ff == fltTop) begin
                nxt_divCnt = `LPT_CNT_W'h0;
                nxt_filtLvl = pinLvl;
                incr = pinLvl;
            end else begin
                nxt_divCnt = divCnt_ff + `LPT_CNT_W'h1;
            end
        end
    end
end

// ************************************************************
// counter, compare flag, outputs
// ************************************************************
reg [`LPT_CNT_W-1:0] nxt_count;
reg nxt_flag;
wire hit = incr && (counter_value == compare_value);

always @* begin
    nxt_count = counter_value;
    nxt_flag = compare_flag;
    if (!timerEnable) begin
        nxt_count = `LPT_CNT_W'h0;
        nxt_flag = 1'b0;
    end else begin
        if (compareFlagClear)
            nxt_flag = 1'b0;
        if (hit)
            nxt_flag = 1'b1;
        if (hit && !free_running_select)
            nxt_count = `LPT_CNT_W'h0;
        else if (incr)
            nxt_count = counter_value + `LPT_CNT_W'h1;
    end
end

// only the block's own reset touches state
// runs from mclk in every power mode
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        divCnt_ff <= `LPT_CNT_W'h0;
        filtLvl_ff <= 1'b0;
        counter_value <= `LPT_CNT_W'h0;
        compare_flag <= 1'b0;
        timerIrq <= 1'b0;
        hwTrigger <= 1'b0;
    end else begin
        divCnt_ff <= nxt_divCnt;
        filtLvl_ff <= nxt_filtLvl;
        counter_value <= nxt_count;
        compare_flag <= nxt_flag;
        timerIrq <= nxt_flag & compare_interrupt_enable;
        hwTrigger <= nxt_flag;
    end
end

endmodule
`default_nettype wire

// ### verification/lpt_pulse_src.sv
// Purpose: far-side model driving comparator and pulse pins
// Assumes: fire is held high for the wanted pulse width
// Notes: edges land 3 ns after mclk, off the sampling grid
`default_nettype none
module lpt_pulse_src (
    input wire logic mclk,
    input wire logic fire,
    input wire logic [1:0] sel,
    output logic [3:0] lines
);
    // unselected lines stay low so stray counts would show
    always @(posedge mclk) lines <= #3 fire ? 4'h1 << sel : 4'h0;
endmodule
`default_nettype wire

// ### verification/lpt_timer_checker.sv
// Purpose: concurrent checks on the timer core outputs
// Assumes: single mclk domain, reset_n async low
// Notes: bound to lpt_timer_core below
`default_nettype none
module lpt_timer_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic timerEnable,
    input wire logic counterMode,
    input wire logic free_running_select,
    input wire logic compare_interrupt_enable,
    input wire logic [15:0] compare_value,
    input wire logic compareFlagClear,
    input wire logic debugHalt,
    input wire logic [15:0] counter_value,
    input wire logic compare_flag,
    input wire logic timerIrq,
    input wire logic hwTrigger
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence halted;
        debugHalt && !counterMode && timerEnable;
    endsequence
    a_off_clears: assert property (
        !timerEnable |=> !compare_flag && counter_value == 16'h0)
        else $error("disable left state behind");
    a_irq_on: assert property (
        compare_flag && $past(compare_interrupt_enable) |-> timerIrq)
        else $error("interrupt missing");
    a_irq_off: assert property (
        !compare_flag || !$past(compare_interrupt_enable) |-> !timerIrq)
        else $error("interrupt without flag");
    a_trig_flag: assert property (
        hwTrigger == compare_flag)
        else $error("trigger differs from flag");
    a_clear_drops: assert property (
        compareFlagClear && timerEnable && counter_value != compare_value
        |=> !compare_flag) else $error("flag not cleared");
    a_flag_match: assert property (
        $rose(compare_flag) |-> $past(timerEnable)
        && $past(counter_value) == $past(compare_value))
        else $error("flag without match");
    a_match_reset: assert property (
        !free_running_select && $rose(compare_flag) |-> counter_value == 16'h0)
        else $error("no reset on match");
    a_free_next: assert property (
        free_running_select && $rose(compare_flag)
        |-> counter_value == 16'($past(counter_value) + 16'h1))
        else $error("free run did not step");
    a_debug_hold: assert property (
        halted [*3] |-> $stable(counter_value))
        else $error("time count moved in debug");
endmodule
bind lpt_timer_core lpt_timer_checker lpt_timer_checker_i (.mclk,
    .reset_n, .timerEnable, .counterMode, .free_running_select,
    .compare_interrupt_enable, .compare_value, .compareFlagClear,
    .debugHalt, .counter_value, .compare_flag, .timerIrq, .hwTrigger);
`default_nettype wire

// ### verification/tb.sv
// Purpose: directed bench for the timer core
// Assumes: source clocks are mclk divided by 8 and more
// Notes: inputs change at the falling edge
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, reset_n = 0, en = 0, mode = 0, pol = 0, byp = 1;
    logic fr = 0, ie = 1, clr = 0, dbg = 0, fire = 0, flag, irq, trig;
    logic [1:0] isel = 0, csel = 0, fsel = 0;
    logic [3:0] pv = 0, lines;
    logic [15:0] cmpv = 16'hffff, cnt, c0;
    logic [7:0] div = 0;
    int err_count = 0, checked = 0;
    always #5 mclk = ~mclk;
    always @(negedge mclk) div <= div + 8'h1;
    lpt_pulse_src lpt_pulse_src_i (.mclk, .fire, .sel(fsel), .lines);
    lpt_timer_core lpt_timer_core_i (.mclk, .reset_n, .timerEnable(en),
        .counterMode(mode), .pulse_input_select(isel),
        .pulse_input_polarity(pol), .prescaler_clock_select(csel),
        .prescaleValue(pv), .prescaleBypass(byp), .free_running_select(fr),
        .compare_interrupt_enable(ie), .compare_value(cmpv),
        .compareFlagClear(clr), .debugHalt(dbg),
        .comparator_output(lines[0]), .pulse_input_pin_n(lines[3:1]),
        .internal_reference_clock(div[2]),
        .low_power_oscillator_1khz(div[3]),
        .slow_external_clock_32k(div[4]),
        .external_reference_clock(div[5]), .counter_value(cnt),
        .compare_flag(flag), .timerIrq(irq), .hwTrigger(trig));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic restart;
        en = 0;
        cyc(2);
        en = 1;
        cyc(2);
    endtask
    // 512 cycles span whole source periods, so the count is exact
    task automatic rate(input int s, input logic b, input int v, input int n);
        csel = 2'(s);
        byp = b;
        pv = 4'(v);
        restart();
        c0 = cnt;
        cyc(512);
        chk(cnt - c0, 16'(n));
    endtask
    task automatic pulse(input int s);
        fsel = 2'(s);
        fire = 1;
        cyc(10);
        fire = 0;
        cyc(10);
    endtask
    task automatic hit;
        for (int i = 0; i < 200 && flag !== 1'b1; i++) cyc(1);
    endtask
    initial begin
        cyc(12);
        reset_n = 1;
        for (int k = 0; k < 4; k++) rate(k, 1, 0, 64 >> k);
        rate(0, 0, 1, 16);
        dbg = 1;
        cyc(4);
        c0 = cnt;
        cyc(100);
        chk(cnt, c0);
        mode = 1;
        byp = 1;
        // pulse mode keeps counting with debug held
        for (int k = 0; k < 4; k++) begin
            isel = 2'(k);
            restart();
            pulse(k + 1);
            pulse(k);
            chk(cnt, 16'h1);
        end
        pol = 1;
        restart();
        fire = 1;
        cyc(10);
        chk(cnt, 16'h0);
        fire = 0;
        cyc(10);
        chk(cnt, 16'h1);
        pol = 0;
        cmpv = 16'h0;
        restart();
        // clear lands on the very edge that sets the flag
        fire = 1;
        cyc(3);
        clr = 1;
        cyc(1);
        clr = 0;
        chk(16'(flag), 16'h1);
        fire = 0;
        cyc(10);
        {dbg, pol, mode, csel, cmpv} = {1'b0, 1'b0, 1'b0, 2'h0, 16'h3};
        restart();
        hit();
        chk(cnt, 16'h0);
        chk(16'(trig), 16'h1);
        chk(16'(irq), 16'h1);
        ie = 0;
        cyc(2);
        chk(16'(irq), 16'h0);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
        chk(16'(flag), 16'h0);
        fr = 1;
        cmpv = 16'h2;
        restart();
        hit();
        chk(cnt, 16'h3);
        en = 0;
        cyc(2);
        chk(cnt + 16'(flag), 16'h0);
        results();
    end
    initial begin
        #100us;
        err_count++;
        results();
    end
endmodule
`default_nettype wire
